//--- logic/hbp_bus_if.sv
// Host bus wires joining the host end and the device port
`timescale 1ns/1ps
interface hbp_bus_if;
  logic [8:0]  reg_select_lines;
  logic [15:0] host_data_h2d;
  logic        host_data_h2d_oe;
  logic [15:0] host_data_d2h;
  logic        host_data_d2h_oe;
  logic        sel_n;
  logic        low_byte_strobe_n;
  logic        high_byte_strobe_n;
  logic        rd_wr;
  logic        transfer_ack_n;
  logic        tx_int_request_n_o;
  logic        tx_int_request_n_oe;
  logic        tx_int_ack_n;
  logic        rx_int_ack_n;
  logic        tx_chain_in_n;
  logic        tx_chain_out_n;
  modport device (
    input  reg_select_lines, host_data_h2d, host_data_h2d_oe, sel_n, low_byte_strobe_n,
    input  high_byte_strobe_n, rd_wr, tx_int_ack_n, rx_int_ack_n, tx_chain_in_n,
    output host_data_d2h, host_data_d2h_oe, transfer_ack_n, tx_int_request_n_o,
    output tx_int_request_n_oe, tx_chain_out_n
  );
  modport host (
    output reg_select_lines, host_data_h2d, host_data_h2d_oe, sel_n, low_byte_strobe_n,
    output high_byte_strobe_n, rd_wr, tx_int_ack_n, rx_int_ack_n, tx_chain_in_n,
    input  host_data_d2h, host_data_d2h_oe, transfer_ack_n, tx_int_request_n_o,
    input  tx_int_request_n_oe, tx_chain_out_n
  );
endinterface : hbp_bus_if

//--- logic/hbp_device_port.sv
// Device end: register access port and transmit vectored interrupt logic
//
// Behaviour
// (RL1) Nine address lines select one register
// (RL2) Sixteen-bit data path, write in, read out
// (RL3) Vector appears on low byte only
// (RL4) Registers answer only while select is low
// (RL5) Byte strobes gate their own byte lane
// (RL6) Direction line high reads, low writes
// (RL7) Acknowledge marks valid read or accepted write
// (RL8) Acknowledge only for select or interrupt acknowledge
// (RL9) Open-drain request while any of six causes
// (RL10) Acknowledge during request starts vector cycle
// (RL11) Vector of highest priority requesting channel
// (RL12) Distinct vector per channel, own chain
// (RL13) Three channels, eight-message queue, empty cause
// (RL14) Claim acknowledge only with chain input low
// (RL15) Chain output low only when nobody requests
// (RL16) Release acknowledge and data after strobes drop
`timescale 1ns/1ps
module hbp_device_port (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  hbp_bus_if.device                          bus,
  input  wire logic [hbp_pkg::NUM_TX_CH-1:0] fifo_empty_in,
  input  wire logic [hbp_pkg::NUM_TX_CH-1:0] tx_end_in,
  input  wire logic [hbp_pkg::NUM_TX_CH-1:0] tx_end_clr_in,
  output wire logic [hbp_pkg::NUM_TX_CH-1:0] tx_end_pend_out,
  output logic      [15:0]                   reg0_out,
  output logic                               ack_cycle_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Register file and answer path state
  logic [hbp_pkg::DATA_W-1:0]    regs_ff [hbp_pkg::NUM_REGS];
  logic [hbp_pkg::DATA_W-1:0]    rdata_ff;
  logic                          drive_ff;
  logic                          ack_ff;
  logic [hbp_pkg::NUM_TX_CH-1:0] end_pend_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Only the low index bits are decoded, so upper address bits alias
  function automatic logic [hbp_pkg::REG_IDX_W-1:0] reg_index(input logic [hbp_pkg::ADDR_W-1:0] addr);
    return addr[hbp_pkg::REG_IDX_W-1:0];
  endfunction : reg_index

  // A lane whose strobe is high reads as zero rather than stale data
  function automatic logic [hbp_pkg::BYTE_W-1:0] lane_gate(input logic                      strobe_n,
                                                           input logic [hbp_pkg::BYTE_W-1:0] value);
    return strobe_n ? '0 : value;
  endfunction : lane_gate

  // Vectors start at the base, one per channel in channel order
  function automatic logic [hbp_pkg::VEC_W-1:0] chan_vector(input int unsigned ch);
    return hbp_pkg::VEC_BASE + hbp_pkg::VEC_W'(ch);
  endfunction : chan_vector

  ////////////////////////////////////////////////////////////////////////////
  // Host cycle decode
  wire logic                          low_on     = ~bus.low_byte_strobe_n;
  wire logic                          high_on    = ~bus.high_byte_strobe_n;
  wire logic                          any_strobe = low_on | high_on;
  wire logic                          reg_cycle  = ~bus.sel_n & any_strobe; // RL4
  wire logic                          is_read    = bus.rd_wr; // RL6
  wire logic [hbp_pkg::REG_IDX_W-1:0] idx        = reg_index(bus.reg_select_lines); // RL1
  wire logic [hbp_pkg::DATA_W-1:0]    cur_reg    = regs_ff[idx];
  wire logic [hbp_pkg::BYTE_W-1:0]    wr_lo_byte = bus.host_data_h2d[hbp_pkg::LO_LSB +: hbp_pkg::BYTE_W];
  wire logic [hbp_pkg::BYTE_W-1:0]    wr_hi_byte = bus.host_data_h2d[hbp_pkg::HI_LSB +: hbp_pkg::BYTE_W];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit causes and daisy-chain priority; channel 0 is the highest
  wire logic [hbp_pkg::NUM_CAUSE-1:0]                   causes;
  wire logic [hbp_pkg::NUM_TX_CH-1:0]                   ch_req;
  wire logic [hbp_pkg::NUM_TX_CH-1:0]                   ch_win;
  wire logic [hbp_pkg::NUM_TX_CH:0]                     above_req;
  wire logic [hbp_pkg::NUM_TX_CH:0][hbp_pkg::VEC_W-1:0] vec_acc;
  wire logic [hbp_pkg::NUM_TX_CH-1:0]                   nxt_end_pend;
  wire logic                                            any_req;
  wire logic [hbp_pkg::VEC_W-1:0]                       vec;

  assign causes       = {end_pend_ff, fifo_empty_in}; // RL13
  assign any_req      = |causes; // RL9
  assign above_req[0] = 1'b0;
  assign vec_acc[0]   = '0;

  genvar ch;
  generate
    for (ch = 0; ch < hbp_pkg::NUM_TX_CH; ch++) begin : g_chan
      assign ch_req[ch]       = fifo_empty_in[ch] | end_pend_ff[ch]; // RL9
      assign ch_win[ch]       = ch_req[ch] & ~above_req[ch]; // RL11
      assign above_req[ch+1]  = above_req[ch] | ch_req[ch];
      assign vec_acc[ch+1]    = vec_acc[ch] | (ch_win[ch] ? chan_vector(ch) : '0); // RL12
      // A new end event wins over a clear landing in the same cycle
      assign nxt_end_pend[ch] = (end_pend_ff[ch] & ~tx_end_clr_in[ch]) | tx_end_in[ch]; // RL13
    end
  endgenerate

  assign vec = vec_acc[hbp_pkg::NUM_TX_CH];

  ////////////////////////////////////////////////////////////////////////////
  // Cycle detection; a chain input that never falls leaves the host waiting
  wire logic iack_cycle;
  wire logic rx_iack;
  wire logic cycle_on;
  wire logic take;
  wire logic vec_take;
  wire logic rd_take;
  wire logic wr_take;

  assign iack_cycle = ~bus.tx_int_ack_n & any_req & ~bus.tx_chain_in_n & any_strobe; // RL10 RL14
  // Receive acknowledge is answered here without data; its vector lives elsewhere
  assign rx_iack    = ~bus.rx_int_ack_n & any_strobe;
  assign cycle_on   = reg_cycle | iack_cycle | rx_iack; // RL8
  // Taking edge: the cycle is open and not yet answered, so a long strobe acts once
  assign take       = cycle_on & ~ack_ff;
  assign vec_take   = take & iack_cycle;
  assign rd_take    = take & reg_cycle & is_read;
  assign wr_take    = take & reg_cycle & ~is_read;

  ////////////////////////////////////////////////////////////////////////////
  // Answer path: data is registered so it stands steady beside the ack
  wire logic [hbp_pkg::BYTE_W-1:0] hi_lane;
  wire logic [hbp_pkg::BYTE_W-1:0] lo_lane;
  wire logic [hbp_pkg::DATA_W-1:0] lane_data;
  wire logic [hbp_pkg::DATA_W-1:0] vec_word;
  wire logic [hbp_pkg::DATA_W-1:0] nxt_rdata;
  wire logic                       nxt_ack;
  wire logic                       nxt_drive;

  assign hi_lane   = cur_reg[hbp_pkg::HI_LSB +: hbp_pkg::BYTE_W];
  assign lo_lane   = cur_reg[hbp_pkg::LO_LSB +: hbp_pkg::BYTE_W];
  assign lane_data = {lane_gate(bus.high_byte_strobe_n, hi_lane),
                      lane_gate(bus.low_byte_strobe_n, lo_lane)}; // RL2 RL5
  assign vec_word  = {{hbp_pkg::BYTE_W{1'b0}}, vec}; // RL3
  assign nxt_rdata = !cycle_on ? hbp_pkg::IDLE_DATA :
                     vec_take  ? vec_word :
                     rd_take   ? lane_data :
                                 rdata_ff;
  assign nxt_ack   = cycle_on; // RL7 RL16
  // Lines are driven only on reads and vectors, so a write never fights the host
  assign nxt_drive = cycle_on & (vec_take | rd_take | drive_ff); // RL16

  ////////////////////////////////////////////////////////////////////////////
  // Pins: the request is open drain, so only its enable moves
  always_comb begin
    bus.tx_int_request_n_o  = 1'b0;
    bus.tx_int_request_n_oe = any_req; // RL9
    bus.tx_chain_out_n      = bus.tx_chain_in_n | any_req; // RL15
    bus.transfer_ack_n      = ~ack_ff; // RL7
    bus.host_data_d2h       = rdata_ff;
    bus.host_data_d2h_oe    = drive_ff; // RL16
  end

  assign tx_end_pend_out = end_pend_ff;
  assign reg0_out        = regs_ff[0];
  assign ack_cycle_out   = ack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Flags and answer registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      end_pend_ff <= '0;
    end else begin
      end_pend_ff <= nxt_end_pend; // RL13
    end
  end

  // The ack drops one edge after the cycle closes, never in mid-cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack; // RL7
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= nxt_drive; // RL16
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= hbp_pkg::IDLE_DATA;
    end else begin
      rdata_ff <= nxt_rdata; // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writes land on the taking edge only, lane by lane
  genvar r;
  generate
    for (r = 0; r < hbp_pkg::NUM_REGS; r++) begin : g_reg
      wire logic wr_hit = wr_take & (idx == hbp_pkg::REG_IDX_W'(r)); // RL1
      wire logic wr_lo  = wr_hit & low_on; // RL5
      wire logic wr_hi  = wr_hit & high_on; // RL2
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          regs_ff[r] <= hbp_pkg::REG_RESET;
        end else begin
          if (wr_lo) begin
            regs_ff[r][hbp_pkg::LO_LSB +: hbp_pkg::BYTE_W] <= wr_lo_byte;
          end
          if (wr_hi) begin
            regs_ff[r][hbp_pkg::HI_LSB +: hbp_pkg::BYTE_W] <= wr_hi_byte;
          end
        end
      end
    end
  endgenerate
endmodule : hbp_device_port

//--- logic/hbp_host_end.sv
// Host end: runs read, write and interrupt acknowledge cycles on the bus
`timescale 1ns/1ps
module hbp_host_end (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  hbp_bus_if.host          bus,
  input  wire logic        req_in,
  input  wire logic [1:0]  op_in,
  input  wire logic [8:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [1:0]  lanes_in,
  input  wire logic        chain_in_n_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      rdata_out,
  output logic             irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  hbp_pkg::hbp_host_e state_ff, nxt_state;
  logic [1:0]  op_ff;
  logic [8:0]  addr_ff;
  logic [15:0] wdata_ff;
  logic [1:0]  lanes_ff;
  logic [15:0] rdata_ff;
  logic        done_ff;

  wire logic active = (state_ff == hbp_pkg::HBP_REQ) | (state_ff == hbp_pkg::HBP_WAIT);
  wire logic is_iack = (op_ff == hbp_pkg::HBP_OP_IACK);
  wire logic acked   = ~bus.transfer_ack_n;

  always_comb begin
    bus.reg_select_lines   = addr_ff;
    bus.host_data_h2d      = wdata_ff;
    bus.host_data_h2d_oe   = active & (op_ff == hbp_pkg::HBP_OP_WRITE);
    bus.sel_n              = ~(active & ~is_iack); // RL4
    bus.low_byte_strobe_n  = ~(active & (lanes_ff[0] | is_iack)); // RL5
    bus.high_byte_strobe_n = ~(active & lanes_ff[1] & ~is_iack);
    bus.rd_wr              = (op_ff != hbp_pkg::HBP_OP_WRITE); // RL6
    bus.tx_int_ack_n       = ~(active & is_iack); // RL10
    bus.rx_int_ack_n       = 1'b1;
    bus.tx_chain_in_n      = chain_in_n_in; // RL14
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hbp_pkg::HBP_IDLE: if (req_in) nxt_state = hbp_pkg::HBP_REQ;
      hbp_pkg::HBP_REQ:  nxt_state = hbp_pkg::HBP_WAIT;
      hbp_pkg::HBP_WAIT: if (acked) nxt_state = hbp_pkg::HBP_DONE;
      hbp_pkg::HBP_DONE: if (!acked) nxt_state = hbp_pkg::HBP_IDLE; // RL16
      default:           nxt_state = hbp_pkg::HBP_IDLE;
    endcase
  end

  assign busy_out  = (state_ff != hbp_pkg::HBP_IDLE);
  assign done_out  = done_ff;
  assign rdata_out = rdata_ff;
  // Request pin is open drain: asserted when device drives it low
  assign irq_out   = bus.tx_int_request_n_oe & ~bus.tx_int_request_n_o;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= hbp_pkg::HBP_IDLE;
      op_ff    <= hbp_pkg::HBP_OP_READ;
      addr_ff  <= '0;
      wdata_ff <= '0;
      lanes_ff <= '0;
      rdata_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff  <= (state_ff == hbp_pkg::HBP_WAIT) & acked;
      if (state_ff == hbp_pkg::HBP_IDLE && req_in) begin
        op_ff    <= op_in;
        addr_ff  <= addr_in;
        wdata_ff <= wdata_in;
        lanes_ff <= lanes_in;
      end
      if (state_ff == hbp_pkg::HBP_WAIT && acked && bus.host_data_d2h_oe) begin
        rdata_ff <= bus.host_data_d2h; // RL7
      end
    end
  end
endmodule : hbp_host_end

//--- logic/hbp_pkg.sv
// Shared constants and types for the host bus port and its host end
package hbp_pkg;
  localparam int          ADDR_W       = 9;
  localparam int          DATA_W       = 16;
  localparam int          VEC_W        = 8;
  localparam int          NUM_TX_CH    = 3;
  localparam int          NUM_CAUSE    = 6;
  localparam int          NUM_REGS     = 16;
  localparam int          REG_IDX_W    = 4;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [7:0]  VEC_BASE     = 8'h40;
  localparam logic [15:0] IDLE_DATA    = 16'h0000;
  localparam int          LO_LSB       = 0;
  localparam int          HI_LSB       = 8;
  localparam int          BYTE_W       = 8;
  typedef enum logic [3:0] {
    HBP_IDLE  = 4'h1,
    HBP_REQ   = 4'h2,
    HBP_WAIT  = 4'h4,
    HBP_DONE  = 4'h8
  } hbp_host_e;
  typedef enum logic [1:0] {
    HBP_OP_READ  = 2'h0,
    HBP_OP_WRITE = 2'h1,
    HBP_OP_IACK  = 2'h2
  } hbp_op_e;
endpackage : hbp_pkg

//--- testbench/hbp_assertions.sv
// Checker for the host bus wires between host end and device port
`timescale 1ns/1ps
module hbp_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        sel_n,
  input wire logic        low_byte_strobe_n,
  input wire logic        high_byte_strobe_n,
  input wire logic        rd_wr,
  input wire logic        transfer_ack_n,
  input wire logic        tx_int_ack_n,
  input wire logic        rx_int_ack_n,
  input wire logic [15:0] host_data_d2h,
  input wire logic        host_data_d2h_oe,
  input wire logic        tx_int_request_n_oe,
  input wire logic        tx_chain_in_n,
  input wire logic        tx_chain_out_n
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  wire strobe = !(low_byte_strobe_n && high_byte_strobe_n);
  wire vec_on = !transfer_ack_n && !tx_int_ack_n && host_data_d2h_oe;
  property p_ack_qual; !transfer_ack_n |-> $past(!sel_n || !tx_int_ack_n || !rx_int_ack_n); endproperty
  a_ack_qual: assert property (p_ack_qual) else $error("ack outside a cycle");
  property p_ack_due; (!sel_n && strobe) |-> ##[1:2] !transfer_ack_n; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack missing");
  property p_release; (!transfer_ack_n && sel_n && tx_int_ack_n && rx_int_ack_n) |=>
    (transfer_ack_n && !host_data_d2h_oe); endproperty
  a_release: assert property (p_release) else $error("ack or data not released");
  property p_vec_hi; vec_on |-> host_data_d2h[15:8] == 8'h00; endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("vector on high byte");
  property p_vec_set; vec_on |-> host_data_d2h[7:0] inside {8'h40, 8'h41, 8'h42}; endproperty
  a_vec_set: assert property (p_vec_set) else $error("vector not a channel vector");
  // Vector claim needs a live request and the chain passed down to us
  property p_claim; ($fell(transfer_ack_n) && sel_n && rx_int_ack_n) |->
    $past(tx_int_request_n_oe && !tx_chain_in_n); endproperty
  a_claim: assert property (p_claim) else $error("iack claimed without right");
  property p_chain; tx_chain_out_n == (tx_chain_in_n || tx_int_request_n_oe); endproperty
  a_chain: assert property (p_chain) else $error("chain output wrong");
  property p_wr; (!transfer_ack_n && !sel_n && !rd_wr) |-> !host_data_d2h_oe; endproperty
  a_wr: assert property (p_wr) else $error("data driven on write");
  property p_rd; (!transfer_ack_n && !sel_n && rd_wr) |-> host_data_d2h_oe; endproperty
  a_rd: assert property (p_rd) else $error("read data not driven");
endmodule : hbp_checker

//--- testbench/tb_host_bus_port_tx_vectored_irq.sv
// Testbench joining host end and device port over the bus interface
`timescale 1ns/1ps
module tb_host_bus_port_tx_vectored_irq;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        req = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [8:0]  addr = 9'h000;
  logic [15:0] wdata = 16'h0000;
  logic [1:0]  lanes = 2'h0;
  logic [2:0]  empty = 3'h0;
  logic [2:0]  tend = 3'h0;
  logic [2:0]  tclr = 3'h0;
  logic [2:0]  pend;
  logic [15:0] rdata;
  logic [15:0] reg0;
  logic        busy;
  logic        done;
  logic        irq;
  logic        chain_n = 1'b0;
  logic        ack_seen;
  int          miscompares = 0;
  int          compares = 0;
  ////////////////////////////////////////
  hbp_bus_if bus();
  hbp_device_port hbp_device_port_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus.device), .fifo_empty_in(empty),
    .tx_end_in(tend), .tx_end_clr_in(tclr), .tx_end_pend_out(pend), .reg0_out(reg0), .ack_cycle_out(ack_seen));
  hbp_host_end hbp_host_end_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus.host), .req_in(req), .op_in(op),
    .addr_in(addr), .wdata_in(wdata), .lanes_in(lanes), .chain_in_n_in(chain_n), .busy_out(busy), .done_out(done),
    .rdata_out(rdata), .irq_out(irq));
  hbp_checker hbp_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .sel_n(bus.sel_n),
    .low_byte_strobe_n(bus.low_byte_strobe_n), .high_byte_strobe_n(bus.high_byte_strobe_n), .rd_wr(bus.rd_wr),
    .transfer_ack_n(bus.transfer_ack_n), .tx_int_ack_n(bus.tx_int_ack_n), .rx_int_ack_n(bus.rx_int_ack_n),
    .host_data_d2h(bus.host_data_d2h), .host_data_d2h_oe(bus.host_data_d2h_oe),
    .tx_int_request_n_oe(bus.tx_int_request_n_oe), .tx_chain_in_n(bus.tx_chain_in_n),
    .tx_chain_out_n(bus.tx_chain_out_n));
  ////////////////////////////////////////
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Start one host cycle; the host end latches it on the next rising edge
  task start_req(input logic [1:0] o, input logic [8:0] a, input logic [15:0] d, input logic [1:0] l);
    @(negedge clk_in);
    op = o;
    addr = a;
    wdata = d;
    lanes = l;
    req = 1'b1;
    @(negedge clk_in);
    req = 1'b0;
  endtask : start_req
  // Bounded wait: an unclaimed vector cycle would otherwise hang the host
  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    chk({15'h0000, done}, 16'h0001);
    repeat (3) @(negedge clk_in);
    chk({15'h0000, busy}, 16'h0000);
  endtask : wait_done
  task xfer(input logic [1:0] o, input logic [8:0] a, input logic [15:0] d, input logic [1:0] l);
    start_req(o, a, d, l);
    wait_done();
  endtask : xfer
  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2000) @(posedge clk_in);
    miscompares++;
    give_verdict();
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk({15'h0000, bus.tx_chain_out_n}, 16'h0000);
    xfer(hbp_pkg::HBP_OP_WRITE, 9'h003, 16'ha5c3, 2'b11);
    xfer(hbp_pkg::HBP_OP_READ, 9'h003, 16'h0000, 2'b11);
    chk(rdata, 16'ha5c3);
    xfer(hbp_pkg::HBP_OP_READ, 9'h103, 16'h0000, 2'b11);
    chk(rdata, 16'ha5c3);
    xfer(hbp_pkg::HBP_OP_READ, 9'h003, 16'h0000, 2'b10);
    chk(rdata, 16'ha500);
    xfer(hbp_pkg::HBP_OP_WRITE, 9'h005, 16'h1234, 2'b01);
    xfer(hbp_pkg::HBP_OP_READ, 9'h005, 16'h0000, 2'b11);
    chk(rdata, 16'h0034);
    xfer(hbp_pkg::HBP_OP_WRITE, 9'h000, 16'hbeef, 2'b11);
    chk(reg0, 16'hbeef);
    for (int k = 1; k < 8; k++) begin
      empty = k[2:0];
      @(negedge clk_in);
      chk({15'h0000, irq}, 16'h0001);
      chk({15'h0000, bus.tx_chain_out_n}, 16'h0001);
      xfer(hbp_pkg::HBP_OP_IACK, 9'h000, 16'h0000, 2'b01);
      chk(rdata, k[0] ? 16'h0040 : (k[1] ? 16'h0041 : 16'h0042));
    end
    empty = 3'h0;
    tend = 3'h4;
    @(negedge clk_in);
    tend = 3'h0;
    @(negedge clk_in);
    chk({13'h0000, pend}, 16'h0004);
    xfer(hbp_pkg::HBP_OP_IACK, 9'h000, 16'h0000, 2'b01);
    chk(rdata, 16'h0042);
    tclr = 3'h4;
    @(negedge clk_in);
    tclr = 3'h0;
    @(negedge clk_in);
    chk({13'h0000, pend}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    tend = 3'h2;
    tclr = 3'h2;
    @(negedge clk_in);
    tend = 3'h0;
    tclr = 3'h0;
    chk({13'h0000, pend}, 16'h0002);
    chain_n = 1'b1;
    @(negedge clk_in);
    chk({15'h0000, bus.tx_chain_out_n}, 16'h0001);
    start_req(hbp_pkg::HBP_OP_IACK, 9'h000, 16'h0000, 2'b01);
    repeat (4) @(negedge clk_in);
    chk({15'h0000, ack_seen}, 16'h0000);
    chk({15'h0000, busy}, 16'h0001);
    chain_n = 1'b0;
    wait_done();
    chk(rdata, 16'h0041);
    tclr = 3'h2;
    @(negedge clk_in);
    tclr = 3'h0;
    @(negedge clk_in);
    chk({13'h0000, pend}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    give_verdict();
  end
endmodule : tb_host_bus_port_tx_vectored_irq
